//--- verilog/scpm_top.sv
// Subclock and power-mode clock gating control with APB registers
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module scpm_top
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rtc_source_strap,
    input  wire logic        wake_event,
    output logic             main_osc_run,
    output logic             sub_osc_run,
    output logic             rtc_clk_en,
    output logic             rtc_clk_from_main,
    output logic             cpu_clk_en,
    output logic             peri_clk_en,
    output logic             pll_run
);
    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [1:0] strap_sync_q;
    logic [1:0] strap_sync_d;
    logic [1:0] wake_sync_q;
    logic [1:0] wake_sync_d;
    logic       strap;
    logic       wake;

    always_comb
    begin
        strap_sync_d = {strap_sync_q[0], rtc_source_strap};
        wake_sync_d  = {wake_sync_q[0], wake_event};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_sync_q <= 2'h0;
            wake_sync_q  <= 2'h0;
        end
        else
        begin
            strap_sync_q <= strap_sync_d;
            wake_sync_q  <= wake_sync_d;
        end
    end

    assign strap = strap_sync_q[1];
    assign wake  = wake_sync_q[1];

    // ---------------------------------------------------------------
    // APB slave and mode state
    // ---------------------------------------------------------------
    logic [scpm_pkg::CTRL_WIDTH-1:0] ctrl_q;
    logic [scpm_pkg::CTRL_WIDTH-1:0] ctrl_d;
    scpm_pkg::scpm_mode_e            mode_q;
    scpm_pkg::scpm_mode_e            mode_d;
    logic [31:0]                     prdata_d;
    logic                            pslverr_d;
    logic                            pready_d;
    logic                            wr;
    logic                            rd;
    logic                            access;
    logic [scpm_pkg::ST_WIDTH-1:0]   gates;
    logic [scpm_pkg::ST_WIDTH-1:0]   gates_q;

    // Single-cycle wait: pready rises one edge after the access starts
    assign access = psel && penable && !pready;
    assign wr     = access && pwrite;
    assign rd     = access && !pwrite;

    always_comb
    begin
        ctrl_d    = ctrl_q;
        mode_d    = mode_q;
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b0;
        pready_d  = access;
        if (wr && paddr == scpm_pkg::CTRL_OFFSET)
        begin
            ctrl_d = pwdata[scpm_pkg::CTRL_WIDTH-1:0];
        end
        else if (wr && paddr == scpm_pkg::CMD_OFFSET)
        begin
            ctrl_d = ctrl_q;
        end
        else if (wr && paddr != scpm_pkg::CMD_OFFSET)
        begin
            pslverr_d = 1'b1;
        end
        if (rd)
        begin
            case (paddr)
                scpm_pkg::CTRL_OFFSET:
                    prdata_d = {25'h0, ctrl_q};
                scpm_pkg::STATUS_OFFSET:
                    prdata_d = {21'h0, 3'(mode_q), 1'b0, gates_q};
                default:
                    pslverr_d = 1'b1;
            endcase
        end
        // Stop request evaluates the mode bits once, on entry
        if (mode_q == scpm_pkg::SCPM_RUN && ctrl_q[scpm_pkg::CTRL_STOP_BIT])
        begin
            if (!ctrl_q[scpm_pkg::CTRL_MOSCD_BIT])
                mode_d = scpm_pkg::SCPM_DUAL_OSC_LOW_POWER;
            else if (!ctrl_q[scpm_pkg::CTRL_SOSCD_BIT] && !strap
                     && ctrl_q[scpm_pkg::CTRL_RTCSUB_BIT])
                mode_d = scpm_pkg::SCPM_SUB_OSC_ONLY;
            else
                mode_d = scpm_pkg::SCPM_FULL_STOP;
        end
        // Wake returns the mode to run and drops the stop request
        if (mode_q != scpm_pkg::SCPM_RUN
            && (wake || (wr && paddr == scpm_pkg::CMD_OFFSET
                         && pwdata[scpm_pkg::CMD_WAKE_BIT])))
        begin
            mode_d = scpm_pkg::SCPM_RUN;
            ctrl_d[scpm_pkg::CTRL_STOP_BIT] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q  <= scpm_pkg::CTRL_RESET;
            mode_q  <= scpm_pkg::SCPM_RUN;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            mode_q  <= mode_d;
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // ---------------------------------------------------------------
    // Clock gate decode and registered outputs
    // ---------------------------------------------------------------
    scpm_gate_decode u_decode
    (
        .strap           (strap),
        .sleep           (ctrl_q[scpm_pkg::CTRL_SLEEP_BIT]),
        .main_pll_enable (ctrl_q[scpm_pkg::CTRL_MPLL_BIT]),
        .sub_osc_enable  (ctrl_q[scpm_pkg::CTRL_SUBEN_BIT]),
        .mode            (mode_q),
        .gates           (gates)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gates_q <= scpm_pkg::ST_RESET;
        else
            gates_q <= gates;
    end

    assign main_osc_run      = gates_q[scpm_pkg::ST_MAIN_OSC_BIT];
    assign sub_osc_run       = gates_q[scpm_pkg::ST_SUB_OSC_BIT];
    assign rtc_clk_en        = gates_q[scpm_pkg::ST_RTC_BIT];
    assign cpu_clk_en        = gates_q[scpm_pkg::ST_CPU_BIT];
    assign peri_clk_en       = gates_q[scpm_pkg::ST_PERI_BIT];
    assign pll_run           = gates_q[scpm_pkg::ST_PLL_BIT];
    assign rtc_clk_from_main = gates_q[scpm_pkg::ST_RTC_SRC_BIT];

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_strap_kills_sub;
        @(posedge pclk) disable iff (!presetn)
        strap_sync_q[1] |=> !sub_osc_run;
    endproperty
    a_strap_kills_sub: assert property (p_strap_kills_sub)
        else $error("sub oscillator runs with strap high");

    property p_sub_needs_enable;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_q[scpm_pkg::CTRL_SUBEN_BIT] |=> !sub_osc_run;
    endproperty
    a_sub_needs_enable: assert property (p_sub_needs_enable)
        else $error("sub oscillator runs without enable");

    property p_sleep_stops_cpu;
        @(posedge pclk) disable iff (!presetn)
        ctrl_q[scpm_pkg::CTRL_SLEEP_BIT] |=> !cpu_clk_en;
    endproperty
    a_sleep_stops_cpu: assert property (p_sleep_stops_cpu)
        else $error("cpu clock runs in sleep");

    property p_run_pll;
        @(posedge pclk) disable iff (!presetn)
        mode_q == scpm_pkg::SCPM_RUN |=> peri_clk_en && main_osc_run
            && pll_run == $past(ctrl_q[scpm_pkg::CTRL_MPLL_BIT]);
    endproperty
    a_run_pll: assert property (p_run_pll)
        else $error("run mode gating wrong");

    property p_dual_rtc;
        @(posedge pclk) disable iff (!presetn)
        mode_q == scpm_pkg::SCPM_DUAL_OSC_LOW_POWER
            |=> main_osc_run && !cpu_clk_en && !peri_clk_en && !pll_run
            && rtc_clk_en == (rtc_clk_from_main || sub_osc_run);
    endproperty
    a_dual_rtc: assert property (p_dual_rtc)
        else $error("dual oscillator mode gating wrong");

    property p_sub_only;
        @(posedge pclk) disable iff (!presetn)
        mode_q == scpm_pkg::SCPM_SUB_OSC_ONLY |=> !main_osc_run && !pll_run
            && !cpu_clk_en && !peri_clk_en;
    endproperty
    a_sub_only: assert property (p_sub_only)
        else $error("sub oscillator only mode gating wrong");

    property p_full_stop;
        @(posedge pclk) disable iff (!presetn)
        mode_q == scpm_pkg::SCPM_FULL_STOP |=> !main_osc_run && !sub_osc_run
            && !rtc_clk_en && !cpu_clk_en && !peri_clk_en && !pll_run;
    endproperty
    a_full_stop: assert property (p_full_stop)
        else $error("full stop leaves a clock on");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        mode_q != scpm_pkg::SCPM_RUN && wake_sync_q[1]
            |=> mode_q == scpm_pkg::SCPM_RUN ##1 peri_clk_en;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake did not restore run");

    property p_rtc_src;
        @(posedge pclk) disable iff (!presetn)
        rtc_clk_en && !rtc_clk_from_main |-> sub_osc_run;
    endproperty
    a_rtc_src: assert property (p_rtc_src)
        else $error("counter clock source not running");
endmodule
`default_nettype wire

//--- inc/scpm_pkg.sv
// Package of constants for the subclock and power-mode clock control block
`default_nettype none
package scpm_pkg;
    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CMD_OFFSET    = 8'h08;
    // ---------------------------------------------------------------
    // Control register fields
    // ---------------------------------------------------------------
    localparam int CTRL_STOP_BIT     = 0;
    localparam int CTRL_MPLL_BIT     = 1;
    localparam int CTRL_SUBEN_BIT    = 2;
    localparam int CTRL_MOSCD_BIT    = 3;
    localparam int CTRL_SOSCD_BIT    = 4;
    localparam int CTRL_RTCSUB_BIT   = 5;
    localparam int CTRL_SLEEP_BIT    = 6;
    localparam int CTRL_WIDTH        = 7;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    // ---------------------------------------------------------------
    // Command register fields (write one to act)
    // ---------------------------------------------------------------
    localparam int CMD_WAKE_BIT      = 0;
    // ---------------------------------------------------------------
    // Status register fields
    // ---------------------------------------------------------------
    localparam int ST_MAIN_OSC_BIT   = 0;
    localparam int ST_SUB_OSC_BIT    = 1;
    localparam int ST_RTC_BIT        = 2;
    localparam int ST_CPU_BIT        = 3;
    localparam int ST_PERI_BIT       = 4;
    localparam int ST_PLL_BIT        = 5;
    localparam int ST_RTC_SRC_BIT    = 6;
    localparam int ST_MODE_LSB       = 8;
    localparam int ST_WIDTH          = 7;
    localparam logic [6:0] ST_RESET  = 7'h00;
    // ---------------------------------------------------------------
    // Power modes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        SCPM_RUN,
        SCPM_DUAL_OSC_LOW_POWER,
        SCPM_SUB_OSC_ONLY,
        SCPM_FULL_STOP
    } scpm_mode_e;
endpackage
`default_nettype wire

//--- verilog/scpm_gate_decode.sv
// Combinational decode of the clock enables for one power mode
`timescale 1ns/1ps
`default_nettype none
module scpm_gate_decode
(
    input  wire logic                   strap,
    input  wire logic                   sleep,
    input  wire logic                   main_pll_enable,
    input  wire logic                   sub_osc_enable,
    input  wire scpm_pkg::scpm_mode_e   mode,
    output logic [scpm_pkg::ST_WIDTH-1:0] gates
);
    logic main_osc;
    logic sub_osc;
    logic rtc;
    logic cpu;
    logic peri;
    logic pll;

    always_comb
    begin
        main_osc = 1'b1;
        sub_osc  = 1'b1;
        rtc      = 1'b1;
        cpu      = 1'b0;
        peri     = 1'b0;
        pll      = 1'b0;
        case (mode)
            scpm_pkg::SCPM_RUN:
            begin
                peri = 1'b1;
                cpu  = !sleep;
                pll  = main_pll_enable;
            end
            scpm_pkg::SCPM_DUAL_OSC_LOW_POWER:
            begin
                rtc = 1'b1;
            end
            scpm_pkg::SCPM_SUB_OSC_ONLY:
            begin
                main_osc = 1'b0;
            end
            scpm_pkg::SCPM_FULL_STOP:
            begin
                main_osc = 1'b0;
                sub_osc  = 1'b0;
                rtc      = 1'b0;
            end
            default:
            begin
                main_osc = 1'b1;
            end
        endcase
        // Sub oscillator only starts when enabled and the strap allows it
        sub_osc = sub_osc && sub_osc_enable && !strap;
        // With the strap low the counter needs the sub oscillator
        if (!strap && !sub_osc)
        begin
            rtc = 1'b0;
        end
        // With the strap high the counter needs the main oscillator
        if (strap && !main_osc)
        begin
            rtc = 1'b0;
        end
        gates = {strap, pll, peri, cpu, rtc, sub_osc, main_osc};
    end
endmodule
`default_nettype wire

//--- tb/scpm_sw_model.sv
// Software-side model: APB master that programs the clock control block
`timescale 1ns/1ps
`default_nettype none
module scpm_sw_model
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // ---------------------------------------------------------------
    // One transfer; caller enters just after a rising edge
    // ---------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er, output logic tmo);
        int n;
        n = 0;
        tmo = 1'b1;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        while (tmo && n < 16)
        begin
            @(posedge pclk);
            n++;
            tmo = (pready !== 1'b1);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Stale data would hide a slave that latches outside the access
        pwdata  <= ~d;
        // Idle edge, so a following call never drives psel twice in one step
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

//--- tb/scpm_tb.sv
// Self-checking testbench for the subclock and power-mode clock control block
`timescale 1ns/1ps
`default_nettype none
module scpm_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rtc_source_strap;
    logic        wake_event;
    logic        main_osc_run;
    logic        sub_osc_run;
    logic        rtc_clk_en;
    logic        rtc_clk_from_main;
    logic        cpu_clk_en;
    logic        peri_clk_en;
    logic        pll_run;
    logic [31:0] rd;
    logic        er;
    int          err_total;
    int          check_count;

    scpm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rtc_source_strap(rtc_source_strap),
        .wake_event(wake_event), .main_osc_run(main_osc_run), .sub_osc_run(sub_osc_run),
        .rtc_clk_en(rtc_clk_en), .rtc_clk_from_main(rtc_clk_from_main),
        .cpu_clk_en(cpu_clk_en), .peri_clk_en(peri_clk_en), .pll_run(pll_run));

    scpm_sw_model sw (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    always #2.5 pclk = ~pclk;

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic test_done();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("Error at %0t: word %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic cmp_gates(input logic [5:0] exp);
        logic [5:0] got;
        got = {pll_run, peri_clk_en, cpu_clk_en, rtc_clk_en, sub_osc_run, main_osc_run};
        check_count++;
        if (got !== exp)
        begin
            $display("Error at %0t: gates %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic tmo;
        sw.xfer(w, a, d, rd, er, tmo);
        if (tmo)
        begin
            $display("Error at %0t: no bus answer", $time);
            err_total++;
            test_done();
        end
    endtask

    // Gate levels need a few edges after a write or wake to settle
    task automatic expect_state(input logic [5:0] g, input logic [2:0] m);
        repeat (4) @(posedge pclk);
        cmp_gates(g);
        bus(1'b0, scpm_pkg::STATUS_OFFSET, 32'h0000_0000);
        cmp_word(rd & 32'h0000_073f, {21'h0, m, 2'h0, g});
    endtask

    task automatic cmd_wake();
        bus(1'b1, scpm_pkg::CMD_OFFSET, 32'h0000_0001);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        expect_state(6'h19, 3'h0);
        bus(1'b0, scpm_pkg::CTRL_OFFSET, 32'h0000_0000);
        cmp_word(rd, 32'h0000_0000);
        bus(1'b0, 8'h0c, 32'h0000_0000);
        cmp_word({31'h0, er}, 32'h0000_0001);
        bus(1'b1, scpm_pkg::STATUS_OFFSET, 32'h0000_007f);
        cmp_word({31'h0, er}, 32'h0000_0001);
        expect_state(6'h19, 3'h0);
    endtask

    task automatic t_run();
        bus(1'b1, scpm_pkg::CTRL_OFFSET, 32'h0000_0006);
        expect_state(6'h3f, 3'h0);
        bus(1'b1, scpm_pkg::CTRL_OFFSET, 32'h0000_0004);
        expect_state(6'h1f, 3'h0);
        bus(1'b1, scpm_pkg::CTRL_OFFSET, 32'h0000_0044);
        expect_state(6'h17, 3'h0);
    endtask

    task automatic t_dual();
        bus(1'b1, scpm_pkg::CTRL_OFFSET, 32'h0000_0007);
        expect_state(6'h07, 3'h1);
        bus(1'b1, scpm_pkg::CTRL_OFFSET, 32'h0000_001f);
        expect_state(6'h07, 3'h1);
        cmd_wake();
        expect_state(6'h3f, 3'h0);
        bus(1'b0, scpm_pkg::CTRL_OFFSET, 32'h0000_0000);
        cmp_word(rd & 32'h0000_0001, 32'h0000_0000);
    endtask

    task automatic t_sub_only();
        bus(1'b1, scpm_pkg::CTRL_OFFSET, 32'h0000_002d);
        expect_state(6'h06, 3'h2);
        wake_event <= 1'b1;
        repeat (2) @(posedge pclk);
        wake_event <= 1'b0;
        expect_state(6'h1f, 3'h0);
    endtask

    // Counter clock restarts with the wake written to the command register
    task automatic t_full_stop();
        bus(1'b1, scpm_pkg::CTRL_OFFSET, 32'h0000_001d);
        expect_state(6'h00, 3'h3);
        cmd_wake();
        expect_state(6'h1f, 3'h0);
    endtask

    task automatic t_strap();
        rtc_source_strap <= 1'b1;
        repeat (4) @(posedge pclk);
        expect_state(6'h1d, 3'h0);
        cmp_word({31'h0, rtc_clk_from_main}, 32'h0000_0001);
        bus(1'b1, scpm_pkg::CTRL_OFFSET, 32'h0000_0005);
        expect_state(6'h05, 3'h1);
        cmd_wake();
        rtc_source_strap <= 1'b0;
        repeat (4) @(posedge pclk);
        expect_state(6'h1f, 3'h0);
        cmp_word({31'h0, rtc_clk_from_main}, 32'h0000_0000);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        pclk             = 1'b0;
        presetn          = 1'b0;
        rtc_source_strap = 1'b0;
        wake_event       = 1'b0;
        err_total        = 0;
        check_count      = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_run();
        t_dual();
        t_sub_only();
        t_full_stop();
        t_strap();
        test_done();
    end
endmodule
`default_nettype wire
